// ---- mapq_host_model.sv ----
`timescale 1ns/1ps

// ----------------------------------------------------------------
// Host side of the register port
// ----------------------------------------------------------------
module mapq_host_model (
    input wire sys_clk, // Core clock
    output logic regWrite, // Write strobe
    output logic regRead, // Read strobe
    output logic [11:0] regAddr, // Register offset
    output logic [31:0] regWdata, // Write data
    input wire [31:0] regRdata_ff, // Read data
    input wire regRvalid_ff // Read data valid
);
    // Idle bus at time zero
    initial begin
        regWrite = 1'b0;
        regRead = 1'b0;
        regAddr = 12'h000;
        regWdata = 32'h00000000;
    end

    // One-cycle write; data inverted after so stale values never match
    task wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        #1 regWrite = 1'b1;
        regAddr = a;
        regWdata = d;
        @(posedge sys_clk);
        #1 regWrite = 1'b0;
        regWdata = ~d;
    endtask

    // One-cycle read; answer taken only when valid stands
    task rd(input logic [11:0] a, output logic [31:0] d);
        @(posedge sys_clk);
        #1 regRead = 1'b1;
        regAddr = a;
        @(posedge sys_clk);
        #1 regRead = 1'b0;
        regAddr = ~a;
        d = regRvalid_ff ? regRdata_ff : 32'hXXXXXXXX;
    endtask
endmodule

// ---- mapq_map.vh ----
`ifndef MAPQ_MAP_VH
`define MAPQ_MAP_VH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define MAPQ_ACTIVE_POWER_ACCUM 12'h39D
`define MAPQ_ACTIVE_ENERGY_LOW 12'h39E
`define MAPQ_ACTIVE_ENERGY_HIGH 12'h39F
`define MAPQ_APPARENT_POWER_ACCUM 12'h3B1
`define MAPQ_APPARENT_ENERGY_LOW 12'h3B2
`define MAPQ_APPARENT_ENERGY_HIGH 12'h3B3
`define MAPQ_REACTIVE_POWER_ACCUM 12'h3BB
`define MAPQ_REACTIVE_ENERGY_LOW 12'h3BC
`define MAPQ_REACTIVE_ENERGY_HIGH 12'h3BD
`define MAPQ_POSITIVE_ACTIVE_ACCUM 12'h3EB
`define MAPQ_NEGATIVE_ACTIVE_ACCUM 12'h3EF
`define MAPQ_POSITIVE_REACTIVE_ACCUM 12'h3F3
`define MAPQ_NEGATIVE_REACTIVE_ACCUM 12'h3F7
`define MAPQ_CURRENT_PEAK 12'h400
`define MAPQ_VOLTAGE_PEAK 12'h401
`define MAPQ_IRQ_STATUS_TIER1 12'h402
`define MAPQ_IRQ_ENABLE_TIER1 12'h405
`define MAPQ_OVERCURRENT_THRESHOLD 12'h409
`define MAPQ_OVERCURRENT_VALUE_A 12'h40A
`define MAPQ_OVERCURRENT_VALUE_B 12'h40B
`define MAPQ_USER_LINE_PERIOD 12'h40E
`define MAPQ_VOLTAGE_LEVEL_REF 12'h40F
`define MAPQ_DIP_THRESHOLD 12'h410
`define MAPQ_DIP_VALUE 12'h411
`define MAPQ_SWELL_THRESHOLD 12'h414
`define MAPQ_SWELL_VALUE 12'h415
`define MAPQ_MEASURED_LINE_PERIOD 12'h418
`define MAPQ_ACTIVE_NOLOAD_THRESHOLD 12'h41C
`define MAPQ_REACTIVE_NOLOAD_THRESHOLD 12'h41D
`define MAPQ_APPARENT_NOLOAD_THRESHOLD 12'h41E
`define MAPQ_NOLOAD_STATE 12'h41F
`define MAPQ_PULSE_RATE_THRESHOLD 12'h420

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define MAPQ_RST_ZERO 32'h00000000
`define MAPQ_RST_OVERCURRENT_THR 32'h00FFFFFF
`define MAPQ_RST_LINE_PERIOD 32'h00500000
`define MAPQ_RST_VOLTAGE_LEVEL 32'h0045D450
`define MAPQ_RST_DIP_VALUE 32'h007FFFFF
`define MAPQ_RST_SWELL_THR 32'h00FFFFFF
`define MAPQ_RST_NOLOAD_THR 32'h00008225
`define MAPQ_RST_PULSE_RATE 32'h00100000

// ----------------------------------------------------------------
// Field positions of the no-load state word
// ----------------------------------------------------------------
`define MAPQ_NL_ACTIVE_BIT 0
`define MAPQ_NL_REACTIVE_BIT 1
`define MAPQ_NL_APPARENT_BIT 2

`endif

// ---- mapq_regs.v ----
`timescale 1ns/1ps
`include "mapq_map.vh"

module mapq_regs (
    input wire sys_clk, // 40 MHz core clock
    input wire reset_n, // Asynchronous reset, active low
    input wire regWrite, // One-cycle register write strobe
    input wire regRead, // One-cycle register read strobe
    input wire [11:0] regAddr, // Register offset
    input wire [31:0] regWdata, // Write data
    output reg [31:0] regRdata_ff, // Read data, one cycle after strobe
    output reg regRvalid_ff, // Read data valid pulse
    input wire sampleStrobe, // One pulse per 4 kSPS sample
    input wire [31:0] instantActivePower, // Signed total active power
    input wire [31:0] instantApparentPower, // Apparent power
    input wire [31:0] instantReactivePower, // Signed reactive power
    input wire [15:0] powerAccumSampleCount, // Samples per power update
    input wire [15:0] energyAccumTime, // Samples per energy update
    input wire energyPulseConfig, // High enables energy accumulation
    input wire [31:0] currentPeakIn, // Current peak from datapath
    input wire [31:0] voltagePeakIn, // Voltage peak from datapath
    input wire rmsStrobe, // Half-cycle fast rms update pulse
    input wire [31:0] currentAFastRms, // Channel A half-cycle fast rms
    input wire [31:0] currentBFastRms, // Channel B half-cycle fast rms
    input wire [31:0] voltageFastRms, // Voltage half-cycle fast rms
    input wire overcurrentAEnable, // Overcurrent detect channel A
    input wire overcurrentBEnable, // Overcurrent detect channel B
    input wire periodStrobe, // New measured line period pulse
    input wire [31:0] measuredPeriodIn, // Measured line period
    input wire userPeriodSelect, // Use programmed period for rms
    input wire [31:0] statusEvents, // Status set pulses, one per bit
    output reg [31:0] rmsPeriod_ff, // Period used by fast rms
    output reg [31:0] voltageLevel_ff, // Level to reactive computation
    output reg [31:0] pulseRateLimit_ff, // Pulse converter rate cap
    output reg irqRequest_ff // Interrupt request, active high
);

// ----------------------------------------------------------------
// Storage
// ----------------------------------------------------------------
reg [31:0] activeAccum_ff; // Published active power
reg [31:0] apparentAccum_ff; // Published apparent power
reg [31:0] reactiveAccum_ff; // Published reactive power
reg [31:0] posActive_ff; // Published positive active
reg [31:0] negActive_ff; // Published negative active
reg [31:0] posReactive_ff; // Published positive reactive
reg [31:0] negReactive_ff; // Published negative reactive
reg [31:0] sumActive_ff; // Running active sum
reg [31:0] sumApparent_ff; // Running apparent sum
reg [31:0] sumReactive_ff; // Running reactive sum
reg [31:0] sumPosAct_ff; // Running positive active sum
reg [31:0] sumNegAct_ff; // Running negative active sum
reg [31:0] sumPosReact_ff; // Running positive reactive sum
reg [31:0] sumNegReact_ff; // Running negative reactive sum
reg [15:0] powerCount_ff; // Samples seen in this power window
reg [63:0] energyActive_ff; // Running active energy
reg [63:0] energyApparent_ff; // Running apparent energy
reg [63:0] energyReactive_ff; // Running reactive energy
reg [63:0] shownActive_ff; // Published active energy pair
reg [63:0] shownApparent_ff; // Published apparent energy pair
reg [63:0] shownReactive_ff; // Published reactive energy pair
reg [15:0] energyCount_ff; // Samples seen in this energy window
reg [31:0] currentPeak_ff; // Current peak
reg [31:0] voltagePeak_ff; // Voltage peak
reg [31:0] status_ff; // Tier-one status
reg [31:0] enable_ff; // Tier-one enable
reg [31:0] ocThreshold_ff; // Overcurrent threshold
reg [31:0] ocValueA_ff; // Captured overcurrent A
reg [31:0] ocValueB_ff; // Captured overcurrent B
reg [31:0] userPeriod_ff; // Programmed line period
reg [31:0] dipThreshold_ff; // Dip threshold
reg [31:0] dipValue_ff; // Captured dip rms
reg [31:0] swellThreshold_ff; // Swell threshold
reg [31:0] swellValue_ff; // Captured swell rms
reg [31:0] measPeriod_ff; // Measured line period
reg [31:0] nlActiveThr_ff; // Active no-load threshold
reg [31:0] nlReactiveThr_ff; // Reactive no-load threshold
reg [31:0] nlApparentThr_ff; // Apparent no-load threshold
reg [2:0] noload_ff; // No-load flags

// ----------------------------------------------------------------
// Sample classification
// ----------------------------------------------------------------
wire actNeg = instantActivePower[31]; // Sign of active sample
wire reactNeg = instantReactivePower[31]; // Sign of reactive sample
wire [31:0] actMag = actNeg ? (~instantActivePower + 32'h00000001)
                            : instantActivePower; // Magnitude
wire [31:0] reactMag = reactNeg
    ? (~instantReactivePower + 32'h00000001)
    : instantReactivePower; // Magnitude of reactive sample
// Window ends on the last counted sample; zero count acts as one
wire powerDone = sampleStrobe &&
    (powerCount_ff + 16'h0001 >= powerAccumSampleCount);
wire energyDone = sampleStrobe &&
    (energyCount_ff + 16'h0001 >= energyAccumTime);
// Final window sums including the sample now arriving
wire [31:0] endActive = sumActive_ff + instantActivePower;
wire [31:0] endApparent = sumApparent_ff + instantApparentPower;
wire [31:0] endReactive = sumReactive_ff + instantReactivePower;
wire [31:0] endActMag = endActive[31] ? (~endActive + 32'h00000001)
                                      : endActive;
wire [31:0] endReactMag = endReactive[31]
    ? (~endReactive + 32'h00000001) : endReactive;
// Sign-extended active and reactive, zero-extended apparent, for the wide energy sums
wire [63:0] wideActive = {{32{actNeg}}, instantActivePower};
wire [63:0] wideReactive = {{32{reactNeg}}, instantReactivePower};
wire [63:0] wideApparent = {32'h00000000, instantApparentPower};

// ----------------------------------------------------------------
// Power accumulation windows
// ----------------------------------------------------------------
// Sums restart with the closing sample excluded, so no sample is
// counted twice across a window edge.
always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
        powerCount_ff <= 16'h0000;
        sumActive_ff <= `MAPQ_RST_ZERO;
        sumApparent_ff <= `MAPQ_RST_ZERO;
        sumReactive_ff <= `MAPQ_RST_ZERO;
        sumPosAct_ff <= `MAPQ_RST_ZERO;
        sumNegAct_ff <= `MAPQ_RST_ZERO;
        sumPosReact_ff <= `MAPQ_RST_ZERO;
        sumNegReact_ff <= `MAPQ_RST_ZERO;
        activeAccum_ff <= `MAPQ_RST_ZERO;
        apparentAccum_ff <= `MAPQ_RST_ZERO;
        reactiveAccum_ff <= `MAPQ_RST_ZERO;
        posActive_ff <= `MAPQ_RST_ZERO;
        negActive_ff <= `MAPQ_RST_ZERO;
        posReactive_ff <= `MAPQ_RST_ZERO;
        negReactive_ff <= `MAPQ_RST_ZERO;
        noload_ff <= 3'h0;
    end else if (powerDone) begin
        // Publish all power results at once
        powerCount_ff <= 16'h0000;
        activeAccum_ff <= endActive;
        apparentAccum_ff <= endApparent;
        reactiveAccum_ff <= endReactive;
        posActive_ff <= actNeg ? sumPosAct_ff
                               : sumPosAct_ff + actMag;
        negActive_ff <= actNeg ? sumNegAct_ff + actMag
                               : sumNegAct_ff;
        posReactive_ff <= reactNeg ? sumPosReact_ff
                                   : sumPosReact_ff + reactMag;
        negReactive_ff <= reactNeg ? sumNegReact_ff + reactMag
                                   : sumNegReact_ff;
        // Below threshold over the window means no load
        noload_ff[`MAPQ_NL_ACTIVE_BIT] <= endActMag < nlActiveThr_ff;
        noload_ff[`MAPQ_NL_REACTIVE_BIT] <=
            endReactMag < nlReactiveThr_ff;
        noload_ff[`MAPQ_NL_APPARENT_BIT] <=
            endApparent < nlApparentThr_ff;
        sumActive_ff <= `MAPQ_RST_ZERO;
        sumApparent_ff <= `MAPQ_RST_ZERO;
        sumReactive_ff <= `MAPQ_RST_ZERO;
        sumPosAct_ff <= `MAPQ_RST_ZERO;
        sumNegAct_ff <= `MAPQ_RST_ZERO;
        sumPosReact_ff <= `MAPQ_RST_ZERO;
        sumNegReact_ff <= `MAPQ_RST_ZERO;
    end else if (sampleStrobe) begin
        // Sums wrap at 32 bits; the host must pick a short window
        powerCount_ff <= powerCount_ff + 16'h0001;
        sumActive_ff <= endActive;
        sumApparent_ff <= endApparent;
        sumReactive_ff <= endReactive;
        if (actNeg) begin
            sumNegAct_ff <= sumNegAct_ff + actMag;
        end else begin
            sumPosAct_ff <= sumPosAct_ff + actMag;
        end
        if (reactNeg) begin
            sumNegReact_ff <= sumNegReact_ff + reactMag;
        end else begin
            sumPosReact_ff <= sumPosReact_ff + reactMag;
        end
    end
end

// ----------------------------------------------------------------
// Energy accumulation
// ----------------------------------------------------------------
// Energy runs on, never cleared, and is copied out as one 64-bit
// snapshot so the low and high words always belong together.
always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
        energyCount_ff <= 16'h0000;
        energyActive_ff <= 64'h0000000000000000;
        energyApparent_ff <= 64'h0000000000000000;
        energyReactive_ff <= 64'h0000000000000000;
        shownActive_ff <= 64'h0000000000000000;
        shownApparent_ff <= 64'h0000000000000000;
        shownReactive_ff <= 64'h0000000000000000;
    end else if (sampleStrobe && energyPulseConfig) begin
        energyActive_ff <= energyActive_ff + wideActive;
        energyApparent_ff <= energyApparent_ff + wideApparent;
        energyReactive_ff <= energyReactive_ff + wideReactive;
        if (energyDone) begin
            energyCount_ff <= 16'h0000;
            shownActive_ff <= energyActive_ff + wideActive;
            shownApparent_ff <= energyApparent_ff + wideApparent;
            shownReactive_ff <= energyReactive_ff + wideReactive;
        end else begin
            energyCount_ff <= energyCount_ff + 16'h0001;
        end
    end
end

// ----------------------------------------------------------------
// Peaks, power quality captures and line period
// ----------------------------------------------------------------
always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
        currentPeak_ff <= `MAPQ_RST_ZERO;
        voltagePeak_ff <= `MAPQ_RST_ZERO;
        ocValueA_ff <= `MAPQ_RST_ZERO;
        ocValueB_ff <= `MAPQ_RST_ZERO;
        dipValue_ff <= `MAPQ_RST_DIP_VALUE;
        swellValue_ff <= `MAPQ_RST_ZERO;
        measPeriod_ff <= `MAPQ_RST_LINE_PERIOD;
        rmsPeriod_ff <= `MAPQ_RST_LINE_PERIOD;
    end else begin
        // Peaks follow the datapath each sample
        if (sampleStrobe) begin
            currentPeak_ff <= currentPeakIn;
            voltagePeak_ff <= voltagePeakIn;
        end
        if (rmsStrobe) begin
            // Overcurrent captures only when enabled and strictly above; dip strictly below, swell strictly above
            if (overcurrentAEnable &&
                currentAFastRms > ocThreshold_ff) begin
                ocValueA_ff <= currentAFastRms;
            end
            if (overcurrentBEnable &&
                currentBFastRms > ocThreshold_ff) begin
                ocValueB_ff <= currentBFastRms;
            end
            if (voltageFastRms < dipThreshold_ff) begin
                dipValue_ff <= voltageFastRms;
            end
            if (voltageFastRms > swellThreshold_ff) begin
                swellValue_ff <= voltageFastRms;
            end
        end
        if (periodStrobe) begin
            measPeriod_ff <= measuredPeriodIn;
        end
        // Period for the one-cycle rms, selected every cycle
        rmsPeriod_ff <= userPeriodSelect ? userPeriod_ff
                                         : measPeriod_ff;
    end
end

// ----------------------------------------------------------------
// Host-writable registers
// ----------------------------------------------------------------
wire statusHit = regWrite && (regAddr == `MAPQ_IRQ_STATUS_TIER1);

always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
        enable_ff <= `MAPQ_RST_ZERO;
        ocThreshold_ff <= `MAPQ_RST_OVERCURRENT_THR;
        userPeriod_ff <= `MAPQ_RST_LINE_PERIOD;
        voltageLevel_ff <= `MAPQ_RST_VOLTAGE_LEVEL;
        dipThreshold_ff <= `MAPQ_RST_ZERO;
        swellThreshold_ff <= `MAPQ_RST_SWELL_THR;
        nlActiveThr_ff <= `MAPQ_RST_NOLOAD_THR;
        nlReactiveThr_ff <= `MAPQ_RST_NOLOAD_THR;
        nlApparentThr_ff <= `MAPQ_RST_NOLOAD_THR;
        pulseRateLimit_ff <= `MAPQ_RST_PULSE_RATE;
    end else if (regWrite) begin
        // Read-only and unmapped offsets ignore writes
        case (regAddr)
            `MAPQ_IRQ_ENABLE_TIER1: enable_ff <= regWdata;
            `MAPQ_OVERCURRENT_THRESHOLD: ocThreshold_ff <= regWdata;
            `MAPQ_USER_LINE_PERIOD: userPeriod_ff <= regWdata;
            `MAPQ_VOLTAGE_LEVEL_REF: voltageLevel_ff <= regWdata;
            `MAPQ_DIP_THRESHOLD: dipThreshold_ff <= regWdata;
            `MAPQ_SWELL_THRESHOLD: swellThreshold_ff <= regWdata;
            `MAPQ_ACTIVE_NOLOAD_THRESHOLD: begin
                nlActiveThr_ff <= regWdata;
            end
            `MAPQ_REACTIVE_NOLOAD_THRESHOLD: begin
                nlReactiveThr_ff <= regWdata;
            end
            `MAPQ_APPARENT_NOLOAD_THRESHOLD: begin
                nlApparentThr_ff <= regWdata;
            end
            `MAPQ_PULSE_RATE_THRESHOLD: begin
                pulseRateLimit_ff <= regWdata;
            end
            default: begin
                // Nothing stored
            end
        endcase
    end
end

// ----------------------------------------------------------------
// Tier-one status and interrupt request
// ----------------------------------------------------------------
// Writing one clears a bit; an event in the same cycle wins.
always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
        status_ff <= `MAPQ_RST_ZERO;
        irqRequest_ff <= 1'b0;
    end else begin
        status_ff <= (status_ff & ~(statusHit ? regWdata : 32'h00000000))
                     | statusEvents;
        // Registered, so the request trails the status by a cycle
        irqRequest_ff <= |(status_ff & enable_ff);
    end
end

// ----------------------------------------------------------------
// Read path
// ----------------------------------------------------------------
// Offset decode for reads
reg [31:0] nxt_rdata; // Selected read word

always @* begin
    nxt_rdata = 32'h00000000;
    case (regAddr)
        `MAPQ_ACTIVE_POWER_ACCUM: nxt_rdata = activeAccum_ff;
        `MAPQ_ACTIVE_ENERGY_LOW: nxt_rdata = shownActive_ff[31:0];
        `MAPQ_ACTIVE_ENERGY_HIGH: nxt_rdata = shownActive_ff[63:32];
        `MAPQ_APPARENT_POWER_ACCUM: nxt_rdata = apparentAccum_ff;
        `MAPQ_APPARENT_ENERGY_LOW: nxt_rdata = shownApparent_ff[31:0];
        `MAPQ_APPARENT_ENERGY_HIGH: nxt_rdata = shownApparent_ff[63:32];
        `MAPQ_REACTIVE_POWER_ACCUM: nxt_rdata = reactiveAccum_ff;
        `MAPQ_REACTIVE_ENERGY_LOW: nxt_rdata = shownReactive_ff[31:0];
        `MAPQ_REACTIVE_ENERGY_HIGH: nxt_rdata = shownReactive_ff[63:32];
        `MAPQ_POSITIVE_ACTIVE_ACCUM: nxt_rdata = posActive_ff;
        `MAPQ_NEGATIVE_ACTIVE_ACCUM: nxt_rdata = negActive_ff;
        `MAPQ_POSITIVE_REACTIVE_ACCUM: nxt_rdata = posReactive_ff;
        `MAPQ_NEGATIVE_REACTIVE_ACCUM: nxt_rdata = negReactive_ff;
        `MAPQ_CURRENT_PEAK: nxt_rdata = currentPeak_ff;
        `MAPQ_VOLTAGE_PEAK: nxt_rdata = voltagePeak_ff;
        `MAPQ_IRQ_STATUS_TIER1: nxt_rdata = status_ff;
        `MAPQ_IRQ_ENABLE_TIER1: nxt_rdata = enable_ff;
        `MAPQ_OVERCURRENT_THRESHOLD: nxt_rdata = ocThreshold_ff;
        `MAPQ_OVERCURRENT_VALUE_A: nxt_rdata = ocValueA_ff;
        `MAPQ_OVERCURRENT_VALUE_B: nxt_rdata = ocValueB_ff;
        `MAPQ_USER_LINE_PERIOD: nxt_rdata = userPeriod_ff;
        `MAPQ_VOLTAGE_LEVEL_REF: nxt_rdata = voltageLevel_ff;
        `MAPQ_DIP_THRESHOLD: nxt_rdata = dipThreshold_ff;
        `MAPQ_DIP_VALUE: nxt_rdata = dipValue_ff;
        `MAPQ_SWELL_THRESHOLD: nxt_rdata = swellThreshold_ff;
        `MAPQ_SWELL_VALUE: nxt_rdata = swellValue_ff;
        `MAPQ_MEASURED_LINE_PERIOD: nxt_rdata = measPeriod_ff;
        `MAPQ_ACTIVE_NOLOAD_THRESHOLD: nxt_rdata = nlActiveThr_ff;
        `MAPQ_REACTIVE_NOLOAD_THRESHOLD: nxt_rdata = nlReactiveThr_ff;
        `MAPQ_APPARENT_NOLOAD_THRESHOLD: nxt_rdata = nlApparentThr_ff;
        `MAPQ_NOLOAD_STATE: nxt_rdata = {29'h0, noload_ff};
        `MAPQ_PULSE_RATE_THRESHOLD: nxt_rdata = pulseRateLimit_ff;
        default: nxt_rdata = 32'h00000000; // Unmapped reads zero
    endcase
end

// Data held until the next read
always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
        regRdata_ff <= 32'h00000000;
        regRvalid_ff <= 1'b0;
    end else begin
        regRvalid_ff <= regRead;
        if (regRead) begin
            regRdata_ff <= nxt_rdata;
        end
    end
end

endmodule

// ---- mapq_regs_props.sv ----
`timescale 1ns/1ps
`include "mapq_map.vh"

// ----------------------------------------------------------------
// Port-level checks of the register bank
// ----------------------------------------------------------------
module mapq_regs_props (
    input wire sys_clk, // Core clock
    input wire reset_n, // Async reset, active low
    input wire regWrite, // Write strobe
    input wire regRead, // Read strobe
    input wire [11:0] regAddr, // Offset
    input wire [31:0] regWdata, // Write data
    input wire [31:0] regRdata_ff, // Read data
    input wire regRvalid_ff, // Read valid
    input wire [31:0] statusEvents, // Status set pulses
    input wire userPeriodSelect, // Period select
    input wire [31:0] rmsPeriod_ff, // Period for rms
    input wire [31:0] voltageLevel_ff, // Voltage level
    input wire [31:0] pulseRateLimit_ff, // Pulse rate cap
    input wire irqRequest_ff // Interrupt request
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!reset_n);
    wire vlWr = regWrite && regAddr == `MAPQ_VOLTAGE_LEVEL_REF; // Level hit
    wire prWr = regWrite && regAddr == `MAPQ_PULSE_RATE_THRESHOLD; // Cap hit
    sequence s_read; regRead; endsequence
    sequence s_gap; !regRead; endsequence
    property p_rvalid; s_read |=> regRvalid_ff; endproperty
    a_rvalid: assert property (p_rvalid) else $error("no read valid");
    property p_norvalid; s_gap |=> !regRvalid_ff; endproperty
    a_norvalid: assert property (p_norvalid) else $error("odd valid");
    property p_rdhold; s_gap |=> $stable(regRdata_ff); endproperty
    a_rdhold: assert property (p_rdhold) else $error("rdata moved");
    property p_unmap; regRead && regAddr == 12'h403 |=> regRdata_ff == 0;
    endproperty
    a_unmap: assert property (p_unmap) else $error("hole not zero");
    property p_vlwr; vlWr |=> voltageLevel_ff == $past(regWdata); endproperty
    a_vlwr: assert property (p_vlwr) else $error("level not set");
    property p_vlhold; !vlWr |=> $stable(voltageLevel_ff); endproperty
    a_vlhold: assert property (p_vlhold) else $error("level moved");
    property p_prwr; prWr |=> pulseRateLimit_ff == $past(regWdata); endproperty
    a_prwr: assert property (p_prwr) else $error("cap not set");
    property p_prhold; !prWr |=> $stable(pulseRateLimit_ff); endproperty
    a_prhold: assert property (p_prhold) else $error("cap moved");
    // Selected user period only moves when the host writes
    property p_per; userPeriodSelect && $past(userPeriodSelect) && !regWrite
        && !$past(regWrite) |=> $stable(rmsPeriod_ff); endproperty
    a_per: assert property (p_per) else $error("period drift");
    // A new request needs an event or any register write two cycles back
    property p_irq; $rose(irqRequest_ff) |->
        $past(statusEvents, 2) != 32'h0 || $past(regWrite, 2); endproperty
    a_irq: assert property (p_irq) else $error("irq no cause");
endmodule
bind mapq_regs mapq_regs_props mapq_regs_props_inst (.sys_clk, .reset_n,
    .regWrite, .regRead, .regAddr, .regWdata, .regRdata_ff, .regRvalid_ff,
    .statusEvents, .userPeriodSelect, .rmsPeriod_ff, .voltageLevel_ff,
    .pulseRateLimit_ff, .irqRequest_ff);

// ---- test_mapq_regs.sv ----
`timescale 1ns/1ps
`include "mapq_map.vh"

module test_mapq_regs;
    logic sys_clk = 0, reset_n = 0, sampleStrobe = 0, rmsStrobe = 0;
    logic periodStrobe = 0, userPeriodSelect = 0; // Datapath pulses
    logic [31:0] act = 0, app = 0, react = 0, rms = 0, per = 0, ev = 0;
    wire regWrite, regRead, regRvalid_ff, irqRequest_ff; // Bus and irq
    wire [11:0] regAddr; // Offset
    wire [31:0] regWdata, regRdata_ff, rmsPeriod_ff, voltageLevel_ff;
    wire [31:0] pulseRateLimit_ff; // Cap output
    int fail_count = 0, check_count = 0, cyc = 0, i; // Report counters
    logic [11:0] rwA[10] = '{12'h405, 12'h409, 12'h40E, 12'h40F, 12'h410,
        12'h414, 12'h41C, 12'h41D, 12'h41E, 12'h420}; // RW offsets
    mapq_host_model mapq_host_model_inst (.sys_clk, .regWrite, .regRead,
        .regAddr, .regWdata, .regRdata_ff, .regRvalid_ff);
    mapq_regs mapq_regs_inst (.sys_clk, .reset_n, .regWrite, .regRead,
        .regAddr, .regWdata, .regRdata_ff, .regRvalid_ff, .sampleStrobe,
        .instantActivePower(act), .instantApparentPower(app),
        .instantReactivePower(react), .powerAccumSampleCount(16'h0003),
        .energyAccumTime(16'h0003), .energyPulseConfig(1'b1),
        .currentPeakIn(act), .voltagePeakIn(react), .rmsStrobe,
        .currentAFastRms(rms), .currentBFastRms(rms), .voltageFastRms(rms),
        .overcurrentAEnable(1'b1), .overcurrentBEnable(1'b0), .periodStrobe,
        .measuredPeriodIn(per), .userPeriodSelect, .statusEvents(ev),
        .rmsPeriod_ff, .voltageLevel_ff, .pulseRateLimit_ff, .irqRequest_ff);
    initial forever #12.5 sys_clk = ~sys_clk;
    // Hang guard, far above the test length
    always @(posedge sys_clk) if (++cyc == 3000) begin
        fail_count++;
        print_verdict();
    end
    task print_verdict();
        if (fail_count == 0 && check_count > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task cmp(input logic [31:0] g, e);
        check_count++;
        if (g !== e) begin
            fail_count++;
            $display("MISMATCH %0t got %h want %h", $time, g, e);
        end
    endtask
    task chk(input logic [11:0] a, input logic [31:0] e);
        logic [31:0] d;
        mapq_host_model_inst.rd(a, d);
        cmp(d, e);
    endtask
    // One sample pulse carrying active, apparent, reactive
    task smp(input logic [31:0] p, s, q);
        @(posedge sys_clk) #1 {act, app, react} = {p, s, q};
        sampleStrobe = 1;
        @(posedge sys_clk) #1 sampleStrobe = 0;
    endtask
    task rmsp(input logic [31:0] v); // One fast rms update
        @(posedge sys_clk) #1 {rmsStrobe, rms} = {1'b1, v};
        @(posedge sys_clk) #1 rmsStrobe = 0;
    endtask
    initial begin
        repeat (12) @(posedge sys_clk);
        #1 reset_n = 1;
        mapq_host_model_inst.wr(12'h418, 32'h0); // Read-only write lost
        chk(12'h418, 32'h00500000);
        chk(12'h40E, 32'h00500000);
        chk(12'h40F, 32'h0045D450);
        chk(12'h411, 32'h007FFFFF);
        chk(12'h414, 32'h00FFFFFF);
        chk(12'h41D, 32'h00008225);
        chk(12'h420, 32'h00100000);
        chk(12'h402, 32'h0);
        chk(12'h403, 32'h0);
        cmp(rmsPeriod_ff, 32'h00500000);
        for (i = 0; i < 10; i++) begin
            mapq_host_model_inst.wr(rwA[i], {20'h0, rwA[i]});
            chk(rwA[i], {20'h0, rwA[i]});
        end
        cmp(voltageLevel_ff, 32'h40F);
        cmp(pulseRateLimit_ff, 32'h420);
        smp(10, 7, -2);
        smp(-4, 7, -2);
        smp(5, 7, 3);
        chk(12'h39D, 11);
        chk(12'h3B1, 21);
        chk(12'h3BB, -1);
        chk(12'h3EB, 15);
        chk(12'h3EF, 4);
        chk(12'h3F3, 3);
        chk(12'h3F7, 4);
        chk(12'h39E, 11);
        chk(12'h39F, 0);
        chk(12'h3BD, -1);
        chk(12'h41F, 7);
        chk(12'h400, 5); // Peak copied per sample
        rmsp(32'h409);
        chk(12'h40A, 0);
        chk(12'h411, 32'h409);
        rmsp(32'h415);
        chk(12'h40A, 32'h415);
        chk(12'h40B, 0);
        chk(12'h411, 32'h409);
        chk(12'h415, 32'h415);
        @(posedge sys_clk) #1 {periodStrobe, per} = {1'b1, 32'h1234};
        @(posedge sys_clk) #1 {periodStrobe, ev} = {1'b0, 32'h8};
        @(posedge sys_clk) #1 ev = 32'h0;
        chk(12'h418, 32'h1234);
        cmp(rmsPeriod_ff, 32'h1234);
        cmp(irqRequest_ff, 0);
        userPeriodSelect = 1;
        @(posedge sys_clk) #1 ev = 32'h4;
        @(posedge sys_clk) #1 ev = 32'h0;
        repeat (2) @(posedge sys_clk) #1;
        cmp(rmsPeriod_ff, 32'h40E);
        cmp(irqRequest_ff, 1);
        mapq_host_model_inst.wr(12'h402, 32'h4);
        repeat (2) @(posedge sys_clk) #1;
        cmp(irqRequest_ff, 0);
        chk(12'h402, 32'h8);
        print_verdict();
    end
endmodule
